// [hdl/event_flag_capture_status.sv]
// Event, status and counter flags of the clock device, behind an APB slave.
// Assumes detector and event pins are asynchronous and the buffer unit and
// supply_sample run on pclk.
`include "evt_flag_map.svh"
`default_nettype none
module event_flag_capture_status (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Asynchronous detector and event pins
  input  wire evt_flag_pkg::det_s  det_level,
  input  wire logic [2:0]          ext_event_input,
  // Buffer unit, same clock
  input  wire logic                supply_sample,
  input  wire logic [2:0]          buf_write,
  input  wire logic [2:0]          buf_full_set,
  input  wire logic [2:0]          buf_ovw_set,
  // Towards buffer unit
  output logic [3:0]               capture_req,
  output logic [2:0]               buffer_clear,
  output logic                     cmd_stamp_trigger
);

  // ********************************************************
  // Input synchronisers and edge detection
  // ********************************************************
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic [6:0] prev_q;
  logic [6:0] rise;
  evt_flag_pkg::det_s det_s;
  evt_flag_pkg::det_s det_rise;
  logic [2:0] ext_lvl;
  logic [2:0] ext_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      prev_q  <= 7'h00;
    end else begin
      sync1_q <= {ext_event_input, det_level};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign rise     = sync2_q & ~prev_q;
  assign det_s    = sync2_q[3:0];
  assign det_rise = rise[3:0];
  assign ext_lvl  = sync2_q[6:4];
  assign ext_rise = rise[6:4];

  // ********************************************************
  // APB access
  // ********************************************************
  logic       pready_q;
  logic [7:0] prdata_q;
  logic       pslverr_q;
  logic [7:0] idx;
  logic       access;
  logic       wr;
  logic [7:0] wd;
  logic [7:0] rd_mux;
  logic       mapped;

  assign idx    = paddr[9:2];
  assign access = psel & penable & ~pready_q;
  assign wr     = psel & penable & pready_q & pwrite & pstrb[0] & mapped;
  assign wd     = pwdata[7:0];

  // Control and flag registers.
  logic [7:0] cfg_q;
  logic [7:0] evt_en_q;
  logic [7:0] capture_source_enable_q;
  logic [2:0] ext_en_q;
  logic [5:0] thr1_q;
  logic [7:0] thr23_q;
  logic [2:0] buf_irq_q;
  logic       bat_stat_q;
  logic       main_stat_q;
  logic [7:0] evt_flag_q;
  logic [2:0] full_q;
  logic [2:0] ovw_q;
  evt_flag_pkg::count_t cnt [3];

  always_comb begin
    mapped = 1'b1;
    rd_mux = `RST_BYTE;
    case (idx)
      `IDX_CMD_CFG:  rd_mux = cfg_q;
      `IDX_CMD_TRG:  rd_mux = `RST_BYTE;
      `IDX_EVT_EN:   rd_mux = evt_en_q;
      `IDX_CAPTURE_SOURCE_ENABLE:   rd_mux = capture_source_enable_q;
      `IDX_BUFFER_INTERRUPT_FLAGS: rd_mux = {buf_irq_q, 1'b0, bat_stat_q, 1'b0, main_stat_q, 1'b0};
      `IDX_EVT_INTF: rd_mux = evt_flag_q;
      `IDX_FULLF:    rd_mux = {1'b0, full_q, 4'h0};
      `IDX_OVWF:     rd_mux = {1'b0, ovw_q, 4'h0};
      `IDX_CNT1:     rd_mux = {2'b00, cnt[0]};
      `IDX_CNT2:     rd_mux = {2'b00, cnt[1]};
      `IDX_CNT3:     rd_mux = {2'b00, cnt[2]};
      `IDX_MON:      rd_mux = {ext_lvl, 5'h00};
      `IDX_EXT_EN:   rd_mux = {5'h00, ext_en_q};
      `IDX_THR1:     rd_mux = {2'b00, thr1_q};
      `IDX_THR23:    rd_mux = thr23_q;
      default:       mapped = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= `RST_BYTE;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= access;
      pslverr_q <= access & ~mapped;
      if (access && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = {24'h000000, prdata_q};

  function automatic logic wr_to(input logic [7:0] a);
    return wr && (idx == a);
  endfunction : wr_to

  // ********************************************************
  // Configuration registers
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q    <= `RST_BYTE;
      evt_en_q <= `RST_BYTE;
      capture_source_enable_q <= `RST_BYTE;
      ext_en_q <= 3'h0;
      thr1_q   <= 6'h00;
      thr23_q  <= `RST_BYTE;
    end else begin
      if (wr_to(`IDX_CMD_CFG)) cfg_q <= wd & `MASK_CMD_CFG;
      if (wr_to(`IDX_EVT_EN)) evt_en_q <= wd & `MASK_EVT_EN;
      if (wr_to(`IDX_CAPTURE_SOURCE_ENABLE)) capture_source_enable_q <= wd & `MASK_CAPTURE_SOURCE_ENABLE;
      if (wr_to(`IDX_EXT_EN)) ext_en_q <= wd[2:0];
      if (wr_to(`IDX_THR1)) thr1_q <= wd[5:0];
      if (wr_to(`IDX_THR23)) thr23_q <= wd;
    end
  end

  // ********************************************************
  // Command trigger
  // ********************************************************
  logic       trig;
  logic [2:0] buf_clr;
  logic       cnt_clr;
  logic [2:0] buffer_clear_q;
  logic       stamp_q;

  assign trig    = wr & (idx == `IDX_CMD_TRG);
  assign buf_clr = {3{trig}} & cfg_q[`POS_CFG_BUFCL +: 3];
  assign cnt_clr = trig & cfg_q[`POS_CFG_CNTCL];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_clear_q <= 3'h0;
      stamp_q        <= 1'b0;
    end else begin
      buffer_clear_q <= buf_clr;
      stamp_q        <= trig & cfg_q[`POS_CFG_STAMP];
    end
  end

  assign buffer_clear      = buffer_clear_q;
  assign cmd_stamp_trigger = stamp_q;

  // ********************************************************
  // Event flags and capture requests
  // ********************************************************
  logic [7:0] evt_set;
  logic [3:0] cap_req_q;
  logic       osc_pend_q;

  assign evt_set = {ext_rise, 1'b0, det_rise} & evt_en_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_flag_q <= `RST_BYTE;
    end else if (wr_to(`IDX_EVT_INTF)) begin
      evt_flag_q <= (evt_flag_q & wd) | evt_set;
    end else begin
      evt_flag_q <= evt_flag_q | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_req_q  <= 4'h0;
      osc_pend_q <= 1'b0;
    end else begin
      cap_req_q[3:1] <= evt_set[3:1] & capture_source_enable_q[3:1];
      if (evt_set[0] && capture_source_enable_q[0]) begin
        osc_pend_q <= 1'b1;
      end else if (!det_s.osc) begin
        osc_pend_q <= 1'b0;
      end
      cap_req_q[0] <= osc_pend_q & ~det_s.osc;
    end
  end

  assign capture_req = cap_req_q;

  // ********************************************************
  // Supply status flags
  // ********************************************************
  logic bat_seen_q;
  logic bat_set;
  logic main_set;
  logic bat_clr;
  logic main_clr;

  assign bat_set  = supply_sample & det_s.battery & bat_seen_q;
  assign main_set = supply_sample & det_s.main;
  assign bat_clr  = wr & (idx == `IDX_BUFFER_INTERRUPT_FLAGS) & ~wd[`POS_BAT_STAT] & ~det_s.battery;
  assign main_clr = wr & (idx == `IDX_BUFFER_INTERRUPT_FLAGS) & ~wd[`POS_MAIN_STAT] & ~det_s.main;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bat_seen_q  <= 1'b0;
      bat_stat_q  <= 1'b0;
      main_stat_q <= 1'b0;
    end else begin
      if (supply_sample) bat_seen_q <= det_s.battery;
      bat_stat_q  <= bat_set | (bat_stat_q & ~bat_clr);
      main_stat_q <= main_set | (main_stat_q & ~main_clr);
    end
  end

  // ********************************************************
  // Per-buffer flags and write counters
  // ********************************************************
  logic [5:0] thr [3];
  logic [5:0] wcnt_q [3];
  logic [2:0] irq_set;

  assign thr[0] = thr1_q;
  assign thr[1] = {2'b00, thr23_q[3:0]};
  assign thr[2] = {2'b00, thr23_q[7:4]};

  for (genvar b = 0; b < 3; b++) begin : g_buf
    logic [5:0] nxt;
    assign nxt        = wcnt_q[b] + 6'h01;
    assign irq_set[b] = buf_write[b] & (nxt == thr[b]) & (thr[b] != 6'h00);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wcnt_q[b] <= 6'h00;
      end else if (buf_clr[b]) begin
        wcnt_q[b] <= 6'h00;
      end else if (buf_write[b]) begin
        wcnt_q[b] <= irq_set[b] ? 6'h00 : nxt;
      end
    end
  end

  logic [7:0] fwd;
  assign fwd = (wr && idx == `IDX_FULLF) ? wd : 8'hFF;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_irq_q <= 3'h0;
      full_q    <= 3'h0;
      ovw_q     <= 3'h0;
    end else begin
      if (wr_to(`IDX_BUFFER_INTERRUPT_FLAGS)) begin
        buf_irq_q <= (buf_irq_q & wd[`POS_BUF_IRQ +: 3]) | irq_set;
      end else begin
        buf_irq_q <= buf_irq_q | irq_set;
      end
      // Buffer 1 full is a plain full flag like the others; reads never clear it.
      full_q <= (full_q & fwd[`POS_FULL +: 3] & ~buf_clr) | buf_full_set;
      ovw_q  <= (ovw_q & ~buf_clr) | buf_ovw_set;
    end
  end

  // ********************************************************
  // External input event counters
  // ********************************************************
  for (genvar n = 0; n < 3; n++) begin : g_cnt
    logic inc;
    assign inc = ext_rise[n] & ext_en_q[n];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt[n] <= 6'h00;
      end else if (cnt_clr) begin
        cnt[n] <= inc ? 6'h01 : 6'h00;
      end else if (inc) begin
        cnt[n] <= cnt[n] + 6'h01;
      end
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_evt_gate_off: assert property (!evt_en_q[3] && !evt_flag_q[3] |=> !evt_flag_q[3])
    else $error("battery event flag set while disabled");
  a_evt_set_wins: assert property (det_rise.comp && evt_en_q[2] |=> evt_flag_q[2])
    else $error("enabled comp supply event lost");
  a_cap_needs_both: assert property (cap_req_q[3] |-> $past(evt_en_q[3] && capture_source_enable_q[3]))
    else $error("capture without both enables");
  a_osc_deferred: assert property (cap_req_q[0] |-> $past(osc_pend_q && !det_s.osc))
    else $error("osc stop capture while stopped");
  a_bat_twice: assert property ($rose(bat_stat_q) |-> $past(bat_seen_q && det_s.battery && supply_sample))
    else $error("battery status set on single detection");
  a_main_hold: assert property (main_stat_q && det_s.main |=> main_stat_q)
    else $error("main status cleared during drop");
  a_cnt_hold: assert property (!ext_en_q[0] && !cnt_clr |=> $stable(cnt[0]))
    else $error("counter moved while disabled");
  a_cnt_step: assert property (ext_rise[1] && ext_en_q[1] && !cnt_clr |=> cnt[1] == $past(cnt[1]) + 6'h01)
    else $error("counter step not one");
  a_ovw_keep: assert property (ovw_q[0] && !buf_clr[0] |=> ovw_q[0])
    else $error("overwrite flag cleared without trigger");
  a_mon_low_zero: assert property (pready_q && !pwrite && idx == `IDX_MON |-> prdata_q[4:0] == 5'h00)
    else $error("monitor low bits not zero");
  a_evt_gate_ext: assert property (!evt_en_q[5] && !evt_flag_q[5] |=> !evt_flag_q[5])
    else $error("input 1 event flag set while disabled");
  a_cap_off_comp: assert property (!capture_source_enable_q[2] |=> !cap_req_q[2])
    else $error("comp supply capture while capture disabled");
  a_irq_at_count: assert property (irq_set[0] |=> buf_irq_q[0])
    else $error("buffer 1 interrupt flag not set at count");
  a_irq_keep: assert property (buf_irq_q[2] && !(wr && idx == `IDX_BUFFER_INTERRUPT_FLAGS && !wd[7]) |=> buf_irq_q[2])
    else $error("buffer 3 interrupt flag cleared without write of zero");
  a_bat_hold: assert property (bat_stat_q && det_s.battery |=> bat_stat_q)
    else $error("battery status cleared during drop");
  a_main_single: assert property (supply_sample && det_s.main |=> main_stat_q)
    else $error("main status not set on one detection");
  a_full_keep: assert property (full_q[0] && !buf_clr[0] && !(wr && idx == `IDX_FULLF && !wd[4]) |=> full_q[0])
    else $error("buffer 1 full flag cleared without write of zero");
  a_stamp_pulse: assert property (trig && cfg_q[`POS_CFG_STAMP] |=> cmd_stamp_trigger)
    else $error("stamp trigger missing after command trigger");
  a_ovw_clear: assert property (buf_clr[0] && !buf_ovw_set[0] |=> !ovw_q[0])
    else $error("overwrite flag survived buffer clear");
  a_cnt_clear: assert property (cnt_clr && !(ext_rise[2] && ext_en_q[2]) |=> cnt[2] == 6'h00)
    else $error("counter not cleared by command trigger");

  c_trigger: cover property (trig && cfg_q[`POS_CFG_CNTCL]);
  c_wrap: cover property (cnt[0] == 6'h3F ##1 cnt[0] == 6'h00);
  c_osc_capture: cover property (osc_pend_q ##[1:50] cap_req_q[0]);
  c_bat_status: cover property ($rose(bat_stat_q));
  c_full_clear: cover property (buf_clr[0] && full_q[0]);

endmodule : event_flag_capture_status
`default_nettype wire

// [hdl/evt_flag_map.svh]
// Register indices, field positions and reset values of the event flag block.
// Assumes APB byte address = 4 * index; data in the low byte of each word.
//
// Operation
// - An enabled detection source sets its own event flag when detected.
// - A disabled source never sets its event flag; the event is dropped.
// - Capture needs both the capture enable and the event enable set.
// - Capture enable holds four bits: battery, comp supply, main, osc stop.
// - Buffer interrupt flag sets when written entries reach the threshold.
// - Buffer interrupt flags clear by writing 0; writing 1 does nothing.
// - Battery low status sets after two successive low detections.
// - Clearing supply status flags works only after the supply recovers.
// - Main supply status sets after one low detection.
// - Event flags 7 to 5 record external inputs; cleared by writing 0.
// - Event flags 3 to 0 hold the detection sources; cleared by writing 0.
// - Oscillator stop capture waits until the oscillator runs again.
// - Full flags stay set until software writes 0 or a command trigger clears that buffer.
// - In queue mode the buffer 1 full flag shows queue status; there is no queue mode, it is a plain full flag.
// - Overwrite flags are read only; cleared by a command trigger.
// - External event counters count 0 to 63 and wrap.
// - A counter holds while its input enable is 0.
// - Monitor shows input levels in bits 7 to 5; low bits read 0.
// - Any write to the trigger register runs the configured actions.
// - Trigger with buffer clear enable resets that buffer's flags and pointer; its buffer interrupt flag is not cleared.
// - Trigger with counter clear enable zeroes all three counters.
`ifndef EVT_FLAG_MAP_SVH
`define EVT_FLAG_MAP_SVH

`define IDX_CMD_CFG   8'h41
`define IDX_CMD_TRG   8'h42
`define IDX_EVT_EN    8'h43
`define IDX_CAPTURE_SOURCE_ENABLE    8'h44
`define IDX_BUFFER_INTERRUPT_FLAGS  8'h46
`define IDX_EVT_INTF  8'h47
`define IDX_FULLF     8'h4E
`define IDX_OVWF      8'h4F
`define IDX_CNT1      8'h51
`define IDX_CNT2      8'h52
`define IDX_CNT3      8'h53
`define IDX_MON       8'h54
`define IDX_EXT_EN    8'h60
`define IDX_THR1      8'h61
`define IDX_THR23     8'h62

`define MASK_CMD_CFG  8'hF1
`define MASK_EVT_EN   8'hEF
`define MASK_CAPTURE_SOURCE_ENABLE   8'h0F
`define MASK_BUFFER_INTERRUPT_FLAGS 8'hEA
`define MASK_EXT_EN   8'h07
`define MASK_THR1     8'h3F

`define POS_BUF_IRQ   5
`define POS_BAT_STAT  3
`define POS_MAIN_STAT 1
`define POS_EXT_FLAG  5
`define POS_FULL      4
`define POS_CFG_BUFCL 4
`define POS_CFG_CNTCL 7
`define POS_CFG_STAMP 0

`define RST_BYTE      8'h00

`endif

// [hdl/evt_flag_pkg.sv]
// Types shared by the event flag block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package evt_flag_pkg;
  // One bit per detection source, ordered as the register bits 3 to 0.
  typedef struct packed {
    logic battery;
    logic comp;
    logic main;
    logic osc;
  } det_s;

  typedef logic [5:0] count_t;
endpackage : evt_flag_pkg
`default_nettype wire

// [bench/event_flag_capture_status_test.sv]
// Self-checking bench for the event flag, status and counter block.
// Assumes the register map header and the package are compiled with the design.
`include "evt_flag_map.svh"
`default_nettype none
module event_flag_capture_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Signals and design instance
  // ************************************************************
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, supply_sample, cmd_stamp_trigger;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata;
  logic [3:0]           capture_req;
  logic [2:0]           ext_event_input, buf_write, buf_full_set, buf_ovw_set, buffer_clear;
  evt_flag_pkg::det_s   det_level;
  int                   mismatches, num_checks, seed, k1, capcnt[4], clrcnt[3], stampcnt, thr[3];
  logic [7:0]           r, lv;
  logic                 e;

  event_flag_capture_status event_flag_capture_status_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .det_level(det_level), .ext_event_input(ext_event_input),
    .supply_sample(supply_sample), .buf_write(buf_write), .buf_full_set(buf_full_set),
    .buf_ovw_set(buf_ovw_set), .capture_req(capture_req), .buffer_clear(buffer_clear),
    .cmd_stamp_trigger(cmd_stamp_trigger));

  always #25 pclk = ~pclk;

  // Counts the one-cycle pulses towards the buffer unit.
  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++) if (capture_req[i] === 1'b1) capcnt[i]++;
    for (int i = 0; i < 3; i++) if (buffer_clear[i] === 1'b1) clrcnt[i]++;
    if (cmd_stamp_trigger === 1'b1) stampcnt++;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // One APB transfer; the request is held until pready is seen high.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready wait", 8'h00, 8'h01);
      results();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00, r, e);
    chk(nm, r, exp);
  endtask : rchk

  task automatic pls(input logic [2:0] w, input logic [2:0] f, input logic [2:0] o, input logic s);
    @(posedge pclk);
    buf_write <= w;
    buf_full_set <= f;
    buf_ovw_set <= o;
    supply_sample <= s;
    @(posedge pclk);
    buf_write <= 3'h0;
    buf_full_set <= 3'h0;
    buf_ovw_set <= 3'h0;
    supply_sample <= 1'b0;
  endtask : pls

  task automatic setdet(input logic [3:0] v);
    @(posedge pclk);
    det_level <= evt_flag_pkg::det_s'(v);
    repeat (6) @(posedge pclk);
  endtask : setdet

  task automatic ext(input logic [2:0] v);
    @(posedge pclk);
    ext_event_input <= v;
    repeat (4) @(posedge pclk);
    ext_event_input <= 3'h0;
    repeat (4) @(posedge pclk);
  endtask : ext

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    #1000000;
    mismatches++;
    results();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, supply_sample} = '0;
    {paddr, pwdata, ext_event_input, buf_write, buf_full_set, buf_ovw_set} = '0;
    det_level = evt_flag_pkg::det_s'(4'h0);
    seed = 37;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (thr[i]) thr[i] = ($unsigned($random(seed)) % 13) + 2;
    thr[0] = 63;
    k1 = ($unsigned($random(seed)) % 8) + 3;
    rchk("capture_source_enable reset", `IDX_CAPTURE_SOURCE_ENABLE, 8'h00);
    rchk("buffer_interrupt_flags reset", `IDX_BUFFER_INTERRUPT_FLAGS, 8'h00);
    rchk("ovw reset", `IDX_OVWF, 8'h00);
    xfer(1'b0, 8'h70, 8'h00, r, e);
    chk("unmapped err", {7'h0, e}, 8'h01);
    wr(`IDX_CAPTURE_SOURCE_ENABLE, 8'hFF);
    rchk("capture_source_enable rw", `IDX_CAPTURE_SOURCE_ENABLE, 8'h0F);
    $display("registers done");
    setdet(4'h8);
    rchk("disabled source", `IDX_EVT_INTF, 8'h00);
    setdet(4'h0);
    wr(`IDX_EVT_EN, 8'h0F);
    wr(`IDX_CAPTURE_SOURCE_ENABLE, 8'h0B);
    setdet(4'hF);
    rchk("source flags", `IDX_EVT_INTF, 8'h0F);
    chk("cap battery", 8'(capcnt[3]), 8'h01);
    chk("cap comp off", 8'(capcnt[2]), 8'h00);
    chk("cap main", 8'(capcnt[1]), 8'h01);
    chk("osc waits", 8'(capcnt[0]), 8'h00);
    setdet(4'h0);
    chk("osc after restart", 8'(capcnt[0]), 8'h01);
    wr(`IDX_EVT_INTF, 8'hFF);
    rchk("flags write one", `IDX_EVT_INTF, 8'h0F);
    wr(`IDX_EVT_INTF, 8'h00);
    rchk("flags write zero", `IDX_EVT_INTF, 8'h00);
    $display("source events done");
    setdet(4'hA);
    pls(3'h0, 3'h0, 3'h0, 1'b1);
    rchk("one sample", `IDX_BUFFER_INTERRUPT_FLAGS, 8'h02);
    pls(3'h0, 3'h0, 3'h0, 1'b1);
    rchk("two samples", `IDX_BUFFER_INTERRUPT_FLAGS, 8'h0A);
    wr(`IDX_BUFFER_INTERRUPT_FLAGS, 8'h00);
    rchk("clear while low", `IDX_BUFFER_INTERRUPT_FLAGS, 8'h0A);
    setdet(4'h0);
    wr(`IDX_BUFFER_INTERRUPT_FLAGS, 8'h00);
    rchk("clear recovered", `IDX_BUFFER_INTERRUPT_FLAGS, 8'h00);
    $display("supply status done");
    wr(`IDX_THR1, 8'(thr[0]));
    wr(`IDX_THR23, {thr[2][3:0], thr[1][3:0]});
    for (int b = 0; b < 3; b++) begin
      repeat (thr[b] - 1) pls(3'(1 << b), 3'h0, 3'h0, 1'b0);
      rchk("irq below count", `IDX_BUFFER_INTERRUPT_FLAGS, 8'h00);
      pls(3'(1 << b), 3'h0, 3'h0, 1'b0);
      rchk("irq at count", `IDX_BUFFER_INTERRUPT_FLAGS, 8'(8'h20 << b));
      wr(`IDX_BUFFER_INTERRUPT_FLAGS, 8'hFF);
      rchk("irq write one", `IDX_BUFFER_INTERRUPT_FLAGS, 8'(8'h20 << b));
      wr(`IDX_BUFFER_INTERRUPT_FLAGS, 8'h00);
      rchk("irq write zero", `IDX_BUFFER_INTERRUPT_FLAGS, 8'h00);
    end
    $display("buffer irq done");
    pls(3'h0, 3'h7, 3'h7, 1'b0);
    wr(`IDX_FULLF, 8'hFF);
    rchk("full write one", `IDX_FULLF, 8'h70);
    wr(`IDX_OVWF, 8'h00);
    rchk("ovw read only", `IDX_OVWF, 8'h70);
    wr(`IDX_FULLF, 8'h00);
    rchk("full write zero", `IDX_FULLF, 8'h00);
    pls(3'h0, 3'h7, 3'h0, 1'b0);
    wr(`IDX_CMD_CFG, 8'h51);
    rchk("cmd cfg", `IDX_CMD_CFG, 8'h51);
    wr(`IDX_CMD_TRG, 8'($random(seed)));
    repeat (3) @(posedge pclk);
    rchk("ovw cleared", `IDX_OVWF, 8'h20);
    rchk("full cleared", `IDX_FULLF, 8'h20);
    chk("clear buf1", 8'(clrcnt[0]), 8'h01);
    chk("clear buf2", 8'(clrcnt[1]), 8'h00);
    chk("clear buf3", 8'(clrcnt[2]), 8'h01);
    chk("stamp trigger", 8'(stampcnt), 8'h01);
    $display("command trigger done");
    wr(`IDX_EVT_EN, 8'hE0);
    wr(`IDX_EXT_EN, 8'h03);
    wr(`IDX_EVT_INTF, 8'h00);
    for (int i = 0; i < 65; i++) ext({2'b11, i < k1});
    rchk("count input1", `IDX_CNT1, 8'(k1));
    rchk("count wraps", `IDX_CNT2, 8'h01);
    rchk("count held", `IDX_CNT3, 8'h00);
    rchk("ext flags", `IDX_EVT_INTF, 8'hE0);
    wr(`IDX_EVT_INTF, 8'h00);
    rchk("ext flags clear", `IDX_EVT_INTF, 8'h00);
    lv = 8'($random(seed));
    @(posedge pclk);
    ext_event_input <= lv[2:0];
    repeat (4) @(posedge pclk);
    rchk("monitor", `IDX_MON, {lv[2:0], 5'h00});
    wr(`IDX_CMD_CFG, 8'h80);
    wr(`IDX_CMD_TRG, 8'h00);
    rchk("count clear 1", `IDX_CNT1, 8'h00);
    rchk("count clear 2", `IDX_CNT2, 8'h00);
    $display("counters done");
    results();
  end
endmodule : event_flag_capture_status_test
`default_nettype wire
